// >>> rtl/rfbl_checker.sv
// Purpose: checks service and block lists of read and write commands
// Assumes: bytes of the data field after the command code, in order
// Notes: first failing check decides the status; rest of frame dropped
//
// How it works
// - at most 15 read, 11 write services
// - any differing service entry is an error
// - each listed block is a 16-byte unit
// - access-mode bits must be zero
// - short element bit7 set, long bit7 clear
// - decode plain, verify or tunnel mode code
// - verify mode legal only in writes
// - upper five bits of third byte zero
// - read allows at most 15 blocks
// - write blocks 12, 11 or verify one
// - plain mode accepts any block order
// - tunnel block numbers must ascend by one
// - all blocks share one communication mode
// - ascending numbers wrap from 0xFF to 0x00
// - service errors report A1 or A3
// - block count errors report A2
// - element errors report A5
// - read is 0x06, write is 0x08
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
module rfbl_checker
  import rfbl_pkg::*;
(
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic [7:0] cmd_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  input wire logic byte_last_in,
  input wire logic [3:0] rd_idx_in,
  output logic done_out,
  output logic pass_out,
  output logic [7:0] status1_out,
  output logic [7:0] status2_out,
  output logic [2:0] mode_out,
  output logic [7:0] blk_total_out,
  output logic [11:0] blk_addr_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in
);

  rfbl_state_t state;
  logic is_write;
  logic svc_first;
  logic long_q;
  logic [7:0] svc_n;
  logic [7:0] svc_left;
  logic [7:0] svc_hi;
  logic [15:0] svc_ref;
  logic [7:0] blk_n;
  logic [7:0] elem_b0;
  logic [7:0] num_q;
  logic [7:0] elem_cnt;
  logic [7:0] prev_num;
  logic [2:0] ref_mode;
  logic [7:0] svc_max;
  logic [7:0] blk_max;
  logic go;
  logic elem_end;
  logic [7:0] cur_num;
  logic [7:0] third_b;
  rfbl_elem_t elem;
  logic fin;
  logic [7:0] fin_code;
  logic [7:0] blk_mem [LIST_DEPTH];
  logic ctrl_en;
  logic [15:0] rej_cnt;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_do;
  logic wr_hit;

  ////////////////////////////////////////////////////////////////////////
  // command accept and limits
  assign go = start_in && ctrl_en &&
              ((cmd_in == CMD_READ) || (cmd_in == CMD_WRITE));
  assign svc_max = is_write ? WR_MAX_SVC : RD_MAX_SVC;
  // write block limit depends on the service count
  always_comb begin
    blk_max = RD_MAX_BLK;
    if (is_write) begin
      blk_max = (svc_n <= WR_SVC_SPLIT) ? WR_MAX_BLK_LO
                                          : WR_MAX_BLK_HI;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // element assembly
  assign elem_end = byte_valid_in &&
                    (((state == S_EL1) && !long_q) || (state == S_EL2));
  assign cur_num = (state == S_EL2) ? num_q : byte_in;
  assign third_b = (state == S_EL2) ? byte_in : 8'h00;

  rfbl_elem_chk u_elem (
    .first_byte_in(elem_b0),
    .third_byte_in(third_b),
    .long_in(long_q),
    .write_in(is_write),
    .first_in(elem_cnt == 8'h00),
    .num_in(cur_num),
    .prev_num_in(prev_num),
    .ref_mode_in(ref_mode),
    .res_out(elem)
  );

  ////////////////////////////////////////////////////////////////////////
  // verdict: the first failing check of the frame ends it
  always_comb begin
    fin = 1'b0;
    fin_code = ST_OK;
    if (byte_valid_in && !go) begin
      if ((state == S_SVCN) &&
          ((byte_in == 8'h00) || (byte_in > svc_max))) begin
        fin = 1'b1;
        fin_code = ERR_SVC_CNT;
      end else if ((state == S_SVC1) && !svc_first &&
                   ({svc_hi, byte_in} != svc_ref)) begin
        fin = 1'b1;
        fin_code = ERR_SVC_DIFF;
      end else if ((state == S_BLKN) &&
                   ((byte_in == 8'h00) || (byte_in > blk_max))) begin
        fin = 1'b1;
        fin_code = ERR_BLK_CNT;
      end else if (elem_end && elem.err) begin
        fin = 1'b1;
        fin_code = ERR_BLK;
      end else if (elem_end && (elem.mode == MODE_VFY) &&
                   (blk_n != VFY_MAX_BLK)) begin
        fin = 1'b1;
        fin_code = ERR_BLK_CNT;
      end else if (elem_end && ((elem_cnt + 8'h01) == blk_n)) begin
        fin = 1'b1;
      end else if (byte_last_in && (state != S_IDLE) &&
                   (state != S_DRAIN)) begin
        fin = 1'b1;
        fin_code = ERR_BLK_CNT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // parse sequencer
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= S_IDLE;
    end else if (go) begin
      state <= S_SVCN;
    end else if (fin) begin
      state <= byte_last_in ? S_IDLE : S_DRAIN;
    end else if (byte_valid_in) begin
      unique case (state)
        S_IDLE: state <= S_IDLE;
        S_SVCN: state <= S_SVC0;
        S_SVC0: state <= S_SVC1;
        S_SVC1: state <= (svc_left == 8'h01) ? S_BLKN : S_SVC0;
        S_BLKN: state <= S_EL0;
        S_EL0: state <= S_EL1;
        S_EL1: state <= long_q ? S_EL2 : S_EL0;
        S_EL2: state <= S_EL0;
        S_DRAIN: state <= byte_last_in ? S_IDLE : S_DRAIN;
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // list header and element byte capture
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      is_write <= 1'b0;
      svc_first <= 1'b1;
      long_q <= 1'b0;
      svc_n <= 8'h00;
      svc_left <= 8'h00;
      svc_hi <= 8'h00;
      svc_ref <= 16'h0000;
      blk_n <= 8'h00;
      elem_b0 <= 8'h00;
      num_q <= 8'h00;
    end else if (go) begin
      is_write <= (cmd_in == CMD_WRITE);
      svc_first <= 1'b1;
    end else if (byte_valid_in) begin
      unique case (state)
        S_SVCN: begin
          svc_n <= byte_in;
          svc_left <= byte_in;
        end
        S_SVC0: svc_hi <= byte_in;
        S_SVC1: begin
          if (svc_first) begin
            svc_ref <= {svc_hi, byte_in};
          end
          svc_first <= 1'b0;
          svc_left <= svc_left - 8'h01;
        end
        S_BLKN: blk_n <= byte_in;
        S_EL0: begin
          elem_b0 <= byte_in;
          long_q <= !byte_in[E0_SHORT_BIT];
        end
        S_EL1: num_q <= byte_in;
        S_IDLE, S_EL2, S_DRAIN: svc_n <= svc_n;
        default: svc_n <= svc_n;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // element history: count, previous number, first mode
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      elem_cnt <= 8'h00;
      prev_num <= 8'h00;
      ref_mode <= MODE_RF;
    end else if (go) begin
      elem_cnt <= 8'h00;
    end else if (elem_end && !elem.err) begin
      elem_cnt <= elem_cnt + 8'h01;
      prev_num <= cur_num;
      if (elem_cnt == 8'h00) begin
        ref_mode <= elem.mode;
      end
    end
  end

  // accepted block numbers, kept in list order
  always_ff @(posedge clk_in) begin
    if (elem_end && !elem.err) begin
      blk_mem[elem_cnt[3:0]] <= cur_num;
    end
  end

  // byte address of a listed 16-byte block
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      blk_addr_out <= 12'h000;
    end else begin
      blk_addr_out <= {blk_mem[rd_idx_in], BLK_BYTE_LSBS};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outcome for the response builder
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      done_out <= 1'b0;
      pass_out <= 1'b0;
      status1_out <= ST_OK;
      status2_out <= ST_OK;
      mode_out <= MODE_RF;
      blk_total_out <= 8'h00;
    end else begin
      done_out <= fin;
      if (go) begin
        pass_out <= 1'b0;
      end else if (fin) begin
        pass_out <= (fin_code == ST_OK);
        status1_out <= (fin_code == ST_OK) ? ST_OK : ST_FAIL;
        status2_out <= fin_code;
        mode_out <= elem.mode;
        blk_total_out <= blk_n;
      end
    end
  end

  // rejected command count; a reject beats a clear
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rej_cnt <= 16'h0000;
    end else if (fin && (fin_code != ST_OK)) begin
      rej_cnt <= rej_cnt + 16'h0001;
    end else if (wr_hit && (aw_addr == ADDR_REJ)) begin
      rej_cnt <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus write channel: address and data in either order
  assign wr_do = !s_axi_awready_out && !s_axi_wready_out &&
                 !s_axi_bvalid_out;
  assign wr_hit = wr_do && ((aw_addr == ADDR_CTRL) ||
                  (aw_addr == ADDR_STAT) || (aw_addr == ADDR_REJ));
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= RESP_OKAY;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // control register: enable gates new commands
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl_en <= CTRL_EN_RESET;
    end else if (wr_hit && (aw_addr == ADDR_CTRL) && w_strb[0]) begin
      ctrl_en <= w_data[0];
    end
  end

  // bus read channel
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= RESP_OKAY;
      unique case (s_axi_araddr_in)
        ADDR_CTRL: s_axi_rdata_out <= {31'h0000_0000, ctrl_en};
        ADDR_STAT: s_axi_rdata_out <= {7'h00, pass_out, blk_total_out,
                                       status2_out, 7'h00,
                                       state != S_IDLE};
        ADDR_REJ: s_axi_rdata_out <= {16'h0000, rej_cnt};
        default: begin
          s_axi_rdata_out <= 32'h0000_0000;
          s_axi_rresp_out <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_byte(rfbl_state_t st);
    byte_valid_in && !go && (state == st);
  endsequence
  sequence s_report(logic [7:0] code);
    done_out && (status2_out == code) ##1 !done_out;
  endsequence

  property p_svc_cnt;
    s_byte(S_SVCN) and (byte_in > svc_max) |=> s_report(ERR_SVC_CNT);
  endproperty
  a_svc_cnt: assert property (p_svc_cnt) else $error("svc count");
  property p_svc_diff;
    s_byte(S_SVC1) and (!svc_first && {svc_hi, byte_in} != svc_ref)
      |=> s_report(ERR_SVC_DIFF);
  endproperty
  a_svc_diff: assert property (p_svc_diff) else $error("svc diff");
  property p_acc_mode;
    elem_end && !go && (elem_b0[6:4] != 3'h0) |=> s_report(ERR_BLK);
  endproperty
  a_acc_mode: assert property (p_acc_mode) else $error("am bits");
  property p_rsv;
    s_byte(S_EL2) and (byte_in[7:3] != 5'h00) |=> s_report(ERR_BLK);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_rd_blk;
    s_byte(S_BLKN) and (!is_write && byte_in > 8'h0F)
      |=> s_report(ERR_BLK_CNT);
  endproperty
  a_rd_blk: assert property (p_rd_blk) else $error("read blocks");
  property p_wr_blk;
    s_byte(S_BLKN) and (is_write && svc_n > 8'h08 && byte_in == 8'h0C)
      |=> s_report(ERR_BLK_CNT);
  endproperty
  a_wr_blk: assert property (p_wr_blk) else $error("write blocks");
  property p_vfy_rd;
    s_byte(S_EL2) and (!is_write && byte_in == 8'h01)
      |=> s_report(ERR_BLK);
  endproperty
  a_vfy_rd: assert property (p_vfy_rd) else $error("verify read");
  property p_ascend;
    s_byte(S_EL2) and (elem_cnt != 8'h00 && ref_mode == MODE_TUN &&
      byte_in == 8'h04 && num_q != prev_num + 8'h01)
      |=> s_report(ERR_BLK);
  endproperty
  a_ascend: assert property (p_ascend) else $error("ascend");
  property p_pass;
    done_out |-> pass_out == (status1_out == 8'h00 && status2_out == 8'h00);
  endproperty
  a_pass: assert property (p_pass) else $error("pass status");
  property p_cmd;
    (state == S_IDLE) && start_in && cmd_in != 8'h06 && cmd_in != 8'h08
      |=> state == S_IDLE;
  endproperty
  a_cmd: assert property (p_cmd) else $error("bad command");

endmodule

// >>> rtl/rfbl_pkg.sv
// Purpose: shared constants and types of the block list checker
// Assumes: one 25 MHz clock, bytes arrive already deframed
// Notes: status codes, limits and field positions are named here once
package rfbl_pkg;

  ////////////////////////////////////////////////////////////////////////
  // command codes and status bytes
  localparam logic [7:0] CMD_READ = 8'h06;
  localparam logic [7:0] CMD_WRITE = 8'h08;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_FAIL = 8'hFF;
  localparam logic [7:0] ERR_SVC_CNT = 8'hA1;
  localparam logic [7:0] ERR_BLK_CNT = 8'hA2;
  localparam logic [7:0] ERR_SVC_DIFF = 8'hA3;
  localparam logic [7:0] ERR_BLK = 8'hA5;

  ////////////////////////////////////////////////////////////////////////
  // count limits
  localparam logic [7:0] RD_MAX_SVC = 8'h0F;
  localparam logic [7:0] WR_MAX_SVC = 8'h0B;
  localparam logic [7:0] RD_MAX_BLK = 8'h0F;
  localparam logic [7:0] WR_SVC_SPLIT = 8'h08;
  localparam logic [7:0] WR_MAX_BLK_LO = 8'h0C;
  localparam logic [7:0] WR_MAX_BLK_HI = 8'h0B;
  localparam logic [7:0] VFY_MAX_BLK = 8'h01;
  localparam logic [7:0] MEM_LAST_BLK = 8'h3F;

  ////////////////////////////////////////////////////////////////////////
  // element field positions and mode codes
  localparam int E0_SHORT_BIT = 7;
  localparam int E0_AM_HI = 6;
  localparam int E0_AM_LO = 4;
  localparam int E2_RSV_HI = 7;
  localparam int E2_RSV_LO = 3;
  localparam int E2_MODE_HI = 2;
  localparam logic [2:0] MODE_RF = 3'h0;
  localparam logic [2:0] MODE_VFY = 3'h1;
  localparam logic [2:0] MODE_TUN = 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // block list storage, 16-byte blocks
  localparam int LIST_DEPTH = 16;
  localparam logic [3:0] BLK_BYTE_LSBS = 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // register map and bus answers
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_REJ = 8'h08;
  localparam logic CTRL_EN_RESET = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_SVCN = 9'h002,
    S_SVC0 = 9'h004,
    S_SVC1 = 9'h008,
    S_BLKN = 9'h010,
    S_EL0 = 9'h020,
    S_EL1 = 9'h040,
    S_EL2 = 9'h080,
    S_DRAIN = 9'h100
  } rfbl_state_t;

  typedef struct packed {
    logic err;
    logic [2:0] mode;
  } rfbl_elem_t;

endpackage

// >>> rtl/rfbl_elem_chk.sv
// Purpose: judges one complete block element against the list so far
// Assumes: inputs are stable in the cycle of the element's last byte
// Notes: purely combinational, the caller registers the verdict
module rfbl_elem_chk
  import rfbl_pkg::*;
(
  input wire logic [7:0] first_byte_in,
  input wire logic [7:0] third_byte_in,
  input wire logic long_in,
  input wire logic write_in,
  input wire logic first_in,
  input wire logic [7:0] num_in,
  input wire logic [7:0] prev_num_in,
  input wire logic [2:0] ref_mode_in,
  output rfbl_elem_t res_out
);

  logic [2:0] mode;
  logic bad_am;
  logic bad_rsv;
  logic legal;
  logic same;
  logic ascend;
  logic in_mem;
  logic [7:0] want_num;

  // short form always means plain access
  assign mode = long_in ? third_byte_in[E2_MODE_HI:0] : MODE_RF;
  assign bad_am = first_byte_in[E0_AM_HI:E0_AM_LO] != 3'h0;
  assign bad_rsv = long_in && (third_byte_in[E2_RSV_HI:E2_RSV_LO] != 5'h00);
  // verify code only counts inside a write
  assign legal = (mode == MODE_RF) || (mode == MODE_TUN) ||
                 ((mode == MODE_VFY) && write_in);
  assign same = first_in || (mode == ref_mode_in);
  // 8-bit add wraps 0xFF to 0x00
  assign want_num = prev_num_in + 8'h01;
  assign ascend = first_in || (mode != MODE_TUN) || (num_in == want_num);
  // plain access must land inside the tag memory, any order allowed
  assign in_mem = (mode != MODE_RF) || (num_in <= MEM_LAST_BLK);

  assign res_out.mode = mode;
  assign res_out.err = bad_am || bad_rsv || !legal || !same || !ascend ||
                       !in_mem;

endmodule

// >>> verification/rfbl_reader.sv
// Purpose: reader model that feeds command bytes to the checker
// Assumes: frames arrive already split into data-field bytes
// Notes: a released data line shows the inverse of its last byte
module rfbl_reader (
  input wire logic clk_in,
  output logic start_out,
  output logic [7:0] cmd_out,
  output logic valid_out,
  output logic [7:0] byte_out,
  output logic last_out
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle at time zero
  initial begin
    {start_out, cmd_out, valid_out, byte_out, last_out} = 19'h00000;
  end

  // start pulse, then bytes with gap idle cycles between them
  task automatic send(input logic [7:0] c, input logic [7:0] q[$],
                      input int gap);
    start_out <= 1'h1;
    cmd_out <= c;
    @(posedge clk_in);
    start_out <= 1'h0;
    cmd_out <= ~c;
    foreach (q[i]) begin
      valid_out <= 1'h1;
      byte_out <= q[i];
      last_out <= (i == q.size() - 1);
      @(posedge clk_in);
      if (gap > 0 || i == q.size() - 1) begin
        valid_out <= 1'h0;
        last_out <= 1'h0;
        byte_out <= ~q[i]; // no stale byte
        repeat (gap) @(posedge clk_in);
      end
    end
  endtask
endmodule

// >>> verification/tb.sv
// Purpose: self-checking bench of the block list checker
// Assumes: 25 MHz clock, reader model drives the byte stream
// Notes: one task per scenario, counts printed before the verdict
module tb
  import rfbl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_in, resetn, start, valid, last, done, pass;
  logic [7:0] cmd, data, st1, st2, total, awaddr, araddr, nb;
  logic [3:0] rd_idx;
  logic [2:0] mode;
  logic [11:0] baddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [7:0] q[$];
  int failures, total_checks, ndone, nrej, cycles, gap;

  initial begin
    clk_in = 1'h0;
    forever #20 clk_in = ~clk_in;
  end

  // verdict counter and cycle ceiling
  always @(posedge clk_in) begin
    cycles++;
    if (done === 1'h1) ndone++;
    if (cycles == 30000) begin
      failures++;
      finish_test();
    end
  end

  rfbl_reader rdr_u (.clk_in(clk_in), .start_out(start), .cmd_out(cmd),
    .valid_out(valid), .byte_out(data), .last_out(last));
  rfbl_checker dut_u (.clk_in(clk_in), .resetn_in(resetn),
    .start_in(start), .cmd_in(cmd), .byte_valid_in(valid),
    .byte_in(data), .byte_last_in(last), .rd_idx_in(rd_idx),
    .done_out(done), .pass_out(pass), .status1_out(st1),
    .status2_out(st2), .mode_out(mode), .blk_total_out(total),
    .blk_addr_out(baddr), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // service list of equal entries, then the block count
  task automatic hdr(input int ns, input logic [7:0] sv, input int n);
    q = {};
    q.push_back(8'(ns));
    repeat (ns) begin
      q.push_back(sv);
      q.push_back(8'h0F);
    end
    nb = 8'(n);
    q.push_back(nb);
  endtask

  task automatic el(input logic [7:0] b0, n, m);
    q.push_back(b0);
    q.push_back(n);
    if (!b0[7]) q.push_back(m);
  endtask

  // send the frame, then judge the verdict
  task automatic run(input logic [7:0] c, s2, input logic [2:0] m);
    int n0 = ndone;
    rdr_u.send(c, q, gap);
    repeat (3) @(posedge clk_in);
    chk(ndone, n0 + 1);
    chk(st2, s2);
    chk(st1, (s2 == ST_OK) ? ST_OK : ST_FAIL);
    chk(pass, s2 == ST_OK);
    if (s2 == ST_OK) begin
      chk(mode, m);
      chk(total, nb);
    end else nrej++;
  endtask

  task automatic addr(input logic [3:0] i, input logic [7:0] n);
    rd_idx <= i;
    repeat (2) @(posedge clk_in);
    chk(baddr, {n, BLK_BYTE_LSBS});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    logic aw = 1'h1;
    logic w = 1'h1;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge clk_in);
      if (aw && awready === 1'h1) begin
        aw = 1'h0;
        awvalid <= 1'h0;
      end
      if (w && wready === 1'h1) begin
        w = 1'h0;
        wvalid <= 1'h0;
      end
    end while (aw || w || bvalid !== 1'h1);
    bready <= 1'h0;
    chk(bresp, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    @(posedge clk_in);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge clk_in); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk_in); while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk(rdata, e);
    chk(rresp, r);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_plain();
    hdr(1, 8'h09, 3);
    el(8'h80, 8'h05, 8'h00);
    el(8'h00, MEM_LAST_BLK, MODE_RF);
    el(8'h8F, 8'h10, 8'h00);
    run(CMD_READ, ST_OK, MODE_RF);
    addr(4'h1, MEM_LAST_BLK);
    addr(4'h2, 8'h10);
  endtask

  // service and block count limits at both sides of each bound
  task automatic t_counts();
    int w [13] = '{0, 0, 1, 1, 0, 0, 0, 1, 1, 1, 1, 1, 0};
    int s [13] = '{15, 16, 11, 12, 0, 1, 15, 8, 8, 9, 9, 11, 1};
    int b [13] = '{1, 1, 1, 1, 1, 15, 16, 12, 13, 11, 12, 11, 0};
    int x [13] = '{0, 1, 0, 1, 1, 0, 2, 0, 2, 0, 2, 0, 2};
    logic [7:0] code [3] = '{ST_OK, ERR_SVC_CNT, ERR_BLK_CNT};
    for (int i = 0; i < 13; i++) begin
      hdr(s[i], 8'h09, b[i]);
      for (int k = 0; k < b[i]; k++) el(8'h80, 8'(k), 8'h00);
      run(w[i] ? CMD_WRITE : CMD_READ, code[x[i]], MODE_RF);
    end
  endtask

  // reserved bits, prohibited codes, far block, unequal services
  task automatic t_elem();
    logic [7:0] b0 [10] = '{8'h90, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'h00, 8'h00, 8'hC0};
    logic [7:0] md [10] = '{8'h00, 8'h00, 8'h08, 8'h80, 8'h02, 8'h03,
      8'h05, 8'h06, 8'h07, 8'h00};
    for (int i = 0; i < 10; i++) begin
      hdr(1, 8'h09, 1);
      el(b0[i], 8'h01, md[i]);
      run(CMD_READ, ERR_BLK, MODE_RF);
    end
    hdr(1, 8'h09, 1);
    el(8'h80, MEM_LAST_BLK + 8'h01, 8'h00);
    run(CMD_READ, ERR_BLK, MODE_RF);
    hdr(3, 8'h09, 1);
    el(8'h80, 8'h01, 8'h00);
    q[4] = 8'h0E;
    run(CMD_READ, ERR_SVC_DIFF, MODE_RF);
  endtask

  // verify and tunnel modes, mixed modes, early frame end
  task automatic t_modes();
    hdr(11, 8'h09, 1);
    el(8'h00, 8'h00, MODE_VFY);
    run(CMD_WRITE, ST_OK, MODE_VFY);
    run(CMD_READ, ERR_BLK, MODE_VFY);
    el(8'h00, 8'h00, MODE_VFY);
    q[23] = 8'h02;
    run(CMD_WRITE, ERR_BLK_CNT, MODE_VFY);
    hdr(2, 8'h09, 4);
    for (int k = 0; k < 4; k++) el(8'h00, 8'hFE + 8'(k), MODE_TUN);
    gap = 2;
    run(CMD_WRITE, ST_OK, MODE_TUN);
    gap = 0;
    addr(4'h3, 8'h01);
    q[13] = 8'h03;
    run(CMD_WRITE, ERR_BLK, MODE_TUN);
    hdr(1, 8'h09, 2);
    el(8'h80, 8'h10, 8'h00);
    el(8'h00, 8'h11, MODE_TUN);
    run(CMD_READ, ERR_BLK, MODE_RF);
    void'(q.pop_back());
    void'(q.pop_back());
    void'(q.pop_back());
    run(CMD_READ, ERR_BLK_CNT, MODE_RF);
  endtask

  // unknown command code and disabled checker give no verdict
  task automatic t_ignore();
    int n0 = ndone;
    rdr_u.send(8'h07, q, 0);
    wr(ADDR_CTRL, 32'h00000000, RESP_OKAY);
    rdr_u.send(CMD_READ, q, 0);
    repeat (3) @(posedge clk_in);
    chk(ndone, n0);
    wr(ADDR_CTRL, 32'h00000001, RESP_OKAY);
  endtask

  task automatic t_regs();
    logic [31:0] stat;
    hdr(1, 8'h09, 2);
    el(8'h80, 8'h01, 8'h00);
    el(8'h80, 8'h02, 8'h00);
    run(CMD_READ, ST_OK, MODE_RF);
    stat = {7'h00, 1'h1, nb, ST_OK, 8'h00};
    rd(ADDR_STAT, stat, RESP_OKAY);
    wr(ADDR_STAT, 32'hFFFFFFFF, RESP_OKAY);
    rd(ADDR_STAT, stat, RESP_OKAY);
    rd(ADDR_REJ, 32'(nrej), RESP_OKAY);
    wr(ADDR_REJ, 32'h00000000, RESP_OKAY);
    rd(ADDR_REJ, 32'h00000000, RESP_OKAY);
    rd(8'h0C, 32'h00000000, RESP_SLVERR);
    wr(8'h0C, 32'h00000000, RESP_SLVERR);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, rd_idx} = 52'h0;
    repeat (10) @(posedge clk_in);
    resetn <= 1'h1;
    chk(st2, ST_OK);
    chk(pass, 1'h0);
    rd(ADDR_CTRL, 32'h00000001, RESP_OKAY);
    t_plain();
    t_counts();
    t_elem();
    t_modes();
    t_ignore();
    t_regs();
    finish_test();
  end
endmodule
